// file: verilog/slcr_pkg.sv
// Package with register map, field layout, reset values and types of the serial link control bank.
package slcr_pkg;

  // Register offsets on the configuration port.
  localparam logic [14:0] SLCR_OFS_LSB_CTRL = 15'h0160;
  localparam logic [14:0] SLCR_OFS_LINK_EN = 15'h0200;
  localparam logic [14:0] SLCR_OFS_MODE = 15'h0201;
  localparam logic [14:0] SLCR_OFS_KM1 = 15'h0202;

  // Field positions and widths.
  localparam int SLCR_STAMP_EN_BIT = 0;
  localparam int SLCR_LINK_EN_BIT = 0;
  localparam int SLCR_MODE_W = 6;
  localparam int SLCR_KM1_W = 8;
  localparam int SLCR_MODE_64B66B_BIT = 5;

  // Values after reset.
  localparam logic SLCR_RST_STAMP_EN = 1'h0;
  localparam logic SLCR_RST_LINK_EN = 1'h1;
  localparam logic [5:0] SLCR_RST_MODE = 6'h00;
  localparam logic [7:0] SLCR_RST_KM1 = 8'h1f;

  // Control bits per sample advertised in the lane alignment sequence.
  localparam logic [1:0] SLCR_ILA_CS = 2'h0;

  // Datapath widths: converter sample and link sample field.
  localparam int SLCR_CONV_W = 9;
  localparam int SLCR_FIELD_W = 16;
  // Flip-flops on the timestamp pin before the datapath reads it.
  localparam int SLCR_SYNC_STAGES = 2;

  // Core cycles per frame and multiframe counter width.
  localparam logic [3:0] SLCR_FRAME_DIV = 4'h4;
  localparam int SLCR_MF_W = 10;
  localparam logic [10:0] SLCR_K_64B_SCALE = 11'h100;

  // Configuration port framing.
  localparam logic [4:0] SLCR_SPI_HDR_LAST = 5'h0f;
  localparam logic [4:0] SLCR_SPI_DATA_FIRST = 5'h10;
  localparam logic [4:0] SLCR_SPI_LAST = 5'h17;

  typedef struct packed {
    logic wr;
    logic [14:0] addr;
    logic [7:0] wdata;
  } slcr_req_t;

  typedef struct packed {
    logic rst_n;
    logic serdes_pd;
    logic clk_en;
  } slcr_link_ctl_t;

endpackage

// file: verilog/slcr_spi.sv
// Configuration port slave: four-wire serial framing into register requests.
`timescale 1ns/1ps
module slcr_spi
  import slcr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic sclk,
  input wire logic csb,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Register side
  output slcr_req_t req,
  output logic wr_stb,
  input wire logic [7:0] rdata
);

  logic [2:0] sclk_q;
  logic [1:0] csb_q;
  logic [1:0] sdi_q;
  logic [4:0] cnt_q;
  logic [22:0] shift_q;
  logic is_rd_q;
  logic [7:0] rd_shift_q;
  logic rise;
  logic fall;
  logic active;

  // Pins pass two flip-flops; the third stage of the clock only feeds edge detection.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 3'h0;
      csb_q <= 2'h3;
      sdi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk};
      csb_q <= {csb_q[0], csb};
      sdi_q <= {sdi_q[0], sdi};
    end
  end

  assign rise = sclk_q[1] & ~sclk_q[2];
  assign fall = ~sclk_q[1] & sclk_q[2];
  assign active = ~csb_q[1];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
      shift_q <= 23'h0;
      is_rd_q <= 1'b0;
      req <= '0;
      wr_stb <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (!active) begin
        cnt_q <= 5'h00;
      end else if (rise && cnt_q <= SLCR_SPI_LAST) begin
        shift_q <= {shift_q[21:0], sdi_q[1]};
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == SLCR_SPI_HDR_LAST) begin
          is_rd_q <= shift_q[14];
          req.addr <= {shift_q[13:0], sdi_q[1]};
          req.wr <= ~shift_q[14];
        end
        if (cnt_q == SLCR_SPI_LAST && !is_rd_q) begin
          req.wdata <= {shift_q[6:0], sdi_q[1]};
          wr_stb <= 1'b1;
        end
      end
    end
  end

  // Read data is shifted out on falling clock edges, most significant bit first.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      rd_shift_q <= 8'h00;
    end else begin
      sdo_oe <= active && is_rd_q && cnt_q >= SLCR_SPI_DATA_FIRST;
      if (active && fall && is_rd_q && cnt_q >= SLCR_SPI_DATA_FIRST) begin
        if (cnt_q == SLCR_SPI_DATA_FIRST) begin
          sdo <= rdata[7];
          rd_shift_q <= {rdata[6:0], 1'b0};
        end else begin
          sdo <= rd_shift_q[7];
          rd_shift_q <= {rd_shift_q[6:0], 1'b0};
        end
      end
    end
  end

endmodule

// file: verilog/slcr_top.sv
// Serial link control bank: registers, link enable control, stamp insertion, multiframe counter.
`timescale 1ns/1ps
// Overview of operation
// - With stamp insertion on, the stamp input rides in the lowest bit of each sample field.
// - The stamp path and the sample path have the same latency so stamps stay aligned.
// - The wider link field keeps the converter sample whole and puts the stamp below it.
// - The lane alignment sequence always advertises zero control bits per sample.
// - The link enable bit turns the link off at 0 and on at 1, and resets to 1.
// - With link enable at 0 the link is in reset, serializers off, link clocks gated.
// - With link enable at 0 the multiframe counter is held in reset and ignores SYSREF.
// - The frames-per-multiframe field holds K minus one and resets to 31 for K of 32.
// - In 64B/66B modes the field is ignored and K is 256 times E over F.
module slcr_top
  import slcr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Configuration port
  input wire logic sclk,
  input wire logic csb,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Sample stream from the converter core
  input wire logic [SLCR_CONV_W-1:0] adc_sample,
  input wire logic adc_valid,
  // Timestamp and SYSREF pins
  input wire logic tmstp_pin,
  input wire logic sysref_pin,
  // Link side
  output logic [SLCR_FIELD_W-1:0] link_sample_q,
  output logic link_sample_valid_q,
  output logic link_enable_q,
  output slcr_link_ctl_t link_ctl_q,
  output logic [SLCR_MODE_W-1:0] link_output_mode_select_q,
  output logic [SLCR_MF_W-1:0] multiframe_counter_q,
  output logic mf_start_q,
  output logic [1:0] ila_cs_q
);

  slcr_req_t req;
  logic wr_stb;
  logic [7:0] rdata_q;
  logic stamp_insert_enable_q;
  logic [SLCR_MODE_W-1:0] mode_q;
  logic [SLCR_KM1_W-1:0] km1_q;
  logic [SLCR_SYNC_STAGES-1:0] tmstp_sync_q;
  logic [2:0] sysref_sync_q;
  logic [SLCR_CONV_W-1:0] smp_d1_q;
  logic [SLCR_CONV_W-1:0] smp_d2_q;
  logic [1:0] vld_q;
  logic [3:0] frame_div_q;
  logic frame_tick;
  logic sysref_rise;
  logic [SLCR_MF_W-1:0] k_last;

  slcr_spi i_slcr_spi (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .csb(csb),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .req(req),
    .wr_stb(wr_stb),
    .rdata(rdata_q)
  );

  // Effective K minus one; 64B/66B modes take E from mode bit 2 and F from mode bits 1:0.
  function automatic logic [SLCR_MF_W-1:0] k_minus_one(input logic [5:0] mode,
                                                      input logic [7:0] km1);
    logic [10:0] e;
    logic [10:0] k;
    e = 11'h001 + {10'h000, mode[2]};
    k = (SLCR_K_64B_SCALE * e) >> mode[1:0];
    if (mode[SLCR_MODE_64B66B_BIT]) begin
      k_minus_one = SLCR_MF_W'(k - 11'h001);
    end else begin
      k_minus_one = {2'h0, km1};
    end
  endfunction

  function automatic logic hit(input slcr_req_t r, input logic [14:0] ofs);
    hit = r.addr == ofs;
  endfunction

  // Register writes. Reserved bits are not stored and read back as zero.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stamp_insert_enable_q <= SLCR_RST_STAMP_EN;
      link_enable_q <= SLCR_RST_LINK_EN;
      mode_q <= SLCR_RST_MODE;
      km1_q <= SLCR_RST_KM1;
    end else if (wr_stb && req.wr) begin
      if (hit(req, SLCR_OFS_LSB_CTRL)) begin
        stamp_insert_enable_q <= req.wdata[SLCR_STAMP_EN_BIT];
      end
      if (hit(req, SLCR_OFS_LINK_EN)) begin
        link_enable_q <= req.wdata[SLCR_LINK_EN_BIT];
      end
      // Mode and K are taken as written; software owns the enable ordering.
      if (hit(req, SLCR_OFS_MODE)) begin
        mode_q <= req.wdata[SLCR_MODE_W-1:0];
      end
      if (hit(req, SLCR_OFS_KM1)) begin
        km1_q <= req.wdata;
      end
    end
  end

  // Read data is registered from the captured address; unmapped offsets read zero.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (hit(req, SLCR_OFS_LSB_CTRL)) begin
      rdata_q <= {7'h00, stamp_insert_enable_q};
    end else if (hit(req, SLCR_OFS_LINK_EN)) begin
      rdata_q <= {7'h00, link_enable_q};
    end else if (hit(req, SLCR_OFS_MODE)) begin
      rdata_q <= {2'h0, mode_q};
    end else if (hit(req, SLCR_OFS_KM1)) begin
      rdata_q <= km1_q;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Link control follows the enable bit one cycle later.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_ctl_q <= '0;
      link_output_mode_select_q <= SLCR_RST_MODE;
      ila_cs_q <= SLCR_ILA_CS;
    end else begin
      link_ctl_q.rst_n <= link_enable_q;
      link_ctl_q.serdes_pd <= ~link_enable_q;
      link_ctl_q.clk_en <= link_enable_q;
      link_output_mode_select_q <= mode_q;
      ila_cs_q <= SLCR_ILA_CS;
    end
  end

  // The stamp pin needs two synchroniser stages; the sample path gets two matching delay stages.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmstp_sync_q <= '0;
      smp_d1_q <= '0;
      smp_d2_q <= '0;
      vld_q <= 2'h0;
    end else begin
      tmstp_sync_q <= {tmstp_sync_q[0], tmstp_pin};
      smp_d1_q <= adc_sample;
      smp_d2_q <= smp_d1_q;
      vld_q <= {vld_q[0], adc_valid};
    end
  end

  // Converter sample is MSB-aligned in the field so its own LSB is never overwritten.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_sample_q <= '0;
      link_sample_valid_q <= 1'b0;
    end else if (!link_enable_q) begin
      link_sample_q <= '0;
      link_sample_valid_q <= 1'b0;
    end else begin
      link_sample_valid_q <= vld_q[1];
      link_sample_q[SLCR_FIELD_W-1 -: SLCR_CONV_W] <= smp_d2_q;
      link_sample_q[SLCR_FIELD_W-SLCR_CONV_W-1:1] <= '0;
      link_sample_q[0] <= stamp_insert_enable_q & tmstp_sync_q[1];
    end
  end

  assign sysref_rise = sysref_sync_q[1] & ~sysref_sync_q[2];
  assign frame_tick = frame_div_q == SLCR_FRAME_DIV - 4'h1;
  assign k_last = k_minus_one(mode_q, km1_q);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysref_sync_q <= 3'h0;
    end else begin
      sysref_sync_q <= {sysref_sync_q[1:0], sysref_pin};
    end
  end

  // A disabled link holds the frame divider and the counter, so SYSREF cannot realign them.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_div_q <= 4'h0;
      multiframe_counter_q <= '0;
      mf_start_q <= 1'b0;
    end else if (!link_enable_q) begin
      frame_div_q <= 4'h0;
      multiframe_counter_q <= '0;
      mf_start_q <= 1'b0;
    end else if (sysref_rise) begin
      frame_div_q <= 4'h0;
      multiframe_counter_q <= '0;
      mf_start_q <= 1'b1;
    end else begin
      frame_div_q <= frame_tick ? 4'h0 : frame_div_q + 4'h1;
      mf_start_q <= frame_tick && multiframe_counter_q == k_last;
      if (frame_tick) begin
        multiframe_counter_q <= multiframe_counter_q == k_last ? '0 :
                                multiframe_counter_q + 10'h001;
      end
    end
  end

  // Checks.
  sequence s_link_en_write(logic v);
    wr_stb && req.wr && req.addr == SLCR_OFS_LINK_EN && req.wdata[0] == v;
  endsequence

  sequence s_link_off;
    !link_enable_q ##1 !link_ctl_q.rst_n && link_ctl_q.serdes_pd && !link_ctl_q.clk_en;
  endsequence

  a_enable_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_link_en_write(1'b0) |=> !link_enable_q ##1 !link_ctl_q.rst_n)
    else $error("link enable write not applied");

  a_link_off_ctl: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_link_en_write(1'b0) |=> s_link_off)
    else $error("link not held off after disable");

  a_mf_held_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !link_enable_q |=> multiframe_counter_q == '0 && !mf_start_q)
    else $error("multiframe counter not held in reset");

  a_mf_wrap_k: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    link_enable_q && !sysref_rise && frame_tick && multiframe_counter_q == k_last
    |=> multiframe_counter_q == '0 && mf_start_q)
    else $error("multiframe counter did not wrap at K");

  a_mf_k64_len: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    mode_q[SLCR_MODE_64B66B_BIT] |-> 11'(k_last) + 11'h001 ==
      (SLCR_K_64B_SCALE * (11'h001 + {10'h000, mode_q[2]})) >> mode_q[1:0])
    else $error("64B/66B effective K wrong");

  a_stamp_lsb: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    link_enable_q && stamp_insert_enable_q && $past(stamp_insert_enable_q) |=>
      link_sample_q[0] == $past(tmstp_pin, 3))
    else $error("stamp bit not on sample LSB");

  a_stamp_latency: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    link_enable_q && $past(stamp_insert_enable_q, 1) && stamp_insert_enable_q |=>
      link_sample_q[SLCR_FIELD_W-SLCR_CONV_W] == $past(adc_sample[0], 3) &&
      link_sample_q[0] == $past(tmstp_pin, 3))
    else $error("stamp and sample latency differ");

  a_conv_lsb_kept: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    link_enable_q |=> link_sample_q[SLCR_FIELD_W-1 -: SLCR_CONV_W] == $past(adc_sample, 3))
    else $error("converter sample not kept whole");

  a_ila_cs_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    stamp_insert_enable_q |-> ila_cs_q == 2'h0)
    else $error("lane alignment control bits not zero");

  sequence s_link_on;
    link_enable_q ##1 link_ctl_q.rst_n && !link_ctl_q.serdes_pd && link_ctl_q.clk_en;
  endsequence

  // Enabling must release the link again, otherwise a disable would be a one-way trip.
  a_link_on_ctl: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_link_en_write(1'b1) |=> s_link_on)
    else $error("link not released after enable");

  a_sample_held_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !link_enable_q |=> link_sample_q == '0 && !link_sample_valid_q)
    else $error("link sample not held off while disabled");

  a_stamp_off_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    link_enable_q && !stamp_insert_enable_q |=> !link_sample_q[0])
    else $error("stamp bit set while insertion is off");

  a_mf_step: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    link_enable_q && !sysref_rise && frame_tick && multiframe_counter_q != k_last
    |=> multiframe_counter_q == $past(multiframe_counter_q) + 10'h001)
    else $error("multiframe counter did not step by one frame");

  a_km1_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_stb && req.wr && req.addr == SLCR_OFS_KM1 |=> km1_q == $past(req.wdata))
    else $error("frames per multiframe write not applied");

endmodule

// file: bench/slcr_rx_model.sv
// Link receiver model that measures the spacing of multiframe boundaries.
`timescale 1ns/1ps
module slcr_rx_model
  import slcr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link side
  input wire logic mf_start_q,
  // Observation
  output logic [15:0] mf_gap_q
);
  logic [15:0] since_q;

  // The gap is the number of core cycles from one boundary to the next.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_q <= 16'h0001;
      mf_gap_q <= 16'h0000;
    end else if (mf_start_q) begin
      since_q <= 16'h0001;
      mf_gap_q <= since_q;
    end else begin
      since_q <= since_q + 16'h0001;
    end
  end
endmodule

// file: bench/slcr_top_test.sv
// Self-checking testbench of the serial link control bank.
`timescale 1ns/1ps
module slcr_top_test
  import slcr_pkg::*;
;
  logic core_clk, rst_n, sclk, csb, sdi, adc_valid, tmstp_pin, sysref_pin;
  logic [8:0] adc_sample;
  logic sdo, sdo_oe, link_sample_valid_q, link_enable_q, mf_start_q;
  logic [15:0] link_sample_q, mf_gap_q;
  slcr_link_ctl_t link_ctl_q;
  logic [5:0] link_output_mode_select_q;
  logic [9:0] multiframe_counter_q;
  logic [1:0] ila_cs_q;
  int miscompares = 0;
  int n_tests = 0;

  slcr_top i_slcr_top (.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .csb(csb), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .adc_sample(adc_sample), .adc_valid(adc_valid),
    .tmstp_pin(tmstp_pin), .sysref_pin(sysref_pin), .link_sample_q(link_sample_q),
    .link_sample_valid_q(link_sample_valid_q), .link_enable_q(link_enable_q),
    .link_ctl_q(link_ctl_q), .link_output_mode_select_q(link_output_mode_select_q),
    .multiframe_counter_q(multiframe_counter_q), .mf_start_q(mf_start_q), .ila_cs_q(ila_cs_q));

  slcr_rx_model i_slcr_rx_model (.core_clk(core_clk), .rst_n(rst_n), .mf_start_q(mf_start_q),
    .mf_gap_q(mf_gap_q));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task wrap_up;
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Outputs are read right after an edge, so they still hold the settled pre-edge value.
  task spi(input logic rw, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q,
           output logic o);
    logic [23:0] w;
    w = {rw, a, d};
    q = 8'h00;
    csb <= 1'b0;
    clk(4);
    for (int i = 23; i >= 0; i--) begin
      sdi <= w[i];
      sclk <= 1'b0;
      clk(5);
      if (i < 8)
        q[i] = sdo;
      sclk <= 1'b1;
      clk(5);
    end
    sclk <= 1'b0;
    clk(5);
    o = sdo_oe;
    csb <= 1'b1;
    sdi <= ~w[0];
    clk(6);
  endtask

  task wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic o;
    spi(1'b0, a, d, q, o);
    chk(16'(o), 16'h0000);
  endtask

  task rd(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic o;
    spi(1'b1, a, 8'h00, q, o);
    chk(16'(q), 16'(e));
    chk(16'(o), 16'h0001);
  endtask

  task wait_mf(input int n, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      clk(1);
      if (mf_start_q === 1'b1)
        hit = 1'b1;
    end
  endtask

  task t_reset;
    logic hit;
    rd(SLCR_OFS_LSB_CTRL, 8'h00);
    rd(SLCR_OFS_LINK_EN, 8'h01);
    rd(SLCR_OFS_MODE, 8'h00);
    rd(SLCR_OFS_KM1, 8'h1f);
    rd(15'h0300, 8'h00);
    chk(16'(link_ctl_q), 16'h0005);
    chk(mf_gap_q, 16'h0080);
    wait_mf(200, hit);
    clk(40);
    sysref_pin <= 1'b1;
    wait_mf(12, hit);
    chk(16'(hit), 16'h0001);
    sysref_pin <= 1'b0;
  endtask

  task t_disable;
    wr(SLCR_OFS_LINK_EN, 8'h00);
    chk(16'(link_enable_q), 16'h0000);
    chk(16'(link_ctl_q), 16'h0002);
    sysref_pin <= 1'b1;
    repeat (10) begin
      clk(1);
      chk(16'({link_sample_valid_q, mf_start_q, multiframe_counter_q}), 16'h0000);
    end
    sysref_pin <= 1'b0;
  endtask

  task t_stream(input logic en);
    logic [8:0] hs [16];
    logic ht [16];
    wr(SLCR_OFS_LSB_CTRL, {7'h00, en});
    wr(SLCR_OFS_LINK_EN, 8'h01);
    for (int k = 0; k < 16; k++) begin
      if (k >= 4) begin
        chk(link_sample_q, {hs[k-4], 6'h00, en & ht[k-4]});
        chk(16'(link_sample_valid_q), {15'h0000, ~k[1]});
      end
      hs[k] = 9'(k * 53 + 161);
      ht[k] = k[0] ^ k[2];
      adc_sample <= hs[k];
      tmstp_pin <= ht[k];
      adc_valid <= ~k[1];
      clk(1);
    end
    chk(16'(link_sample_valid_q), 16'h0001);
    chk(16'(ila_cs_q), 16'h0000);
    wr(SLCR_OFS_LINK_EN, 8'h00);
  endtask

  task t_mf;
    wr(SLCR_OFS_KM1, 8'h01);
    wr(SLCR_OFS_LINK_EN, 8'h01);
    clk(30);
    chk(mf_gap_q, 16'h0008);
    wr(SLCR_OFS_LINK_EN, 8'h00);
    // Mode 0x27 is a 64B/66B mode with E of 2 and F of 8, so K is 64 whatever the field holds.
    wr(SLCR_OFS_MODE, 8'h27);
    wr(SLCR_OFS_LINK_EN, 8'h01);
    clk(600);
    chk(mf_gap_q, 16'h0100);
    chk(16'(link_output_mode_select_q), 16'h0027);
    rd(SLCR_OFS_MODE, 8'h27);
  endtask

  initial begin
    rst_n = 1'b0;
    sclk = 1'b0;
    csb = 1'b1;
    sdi = 1'b0;
    adc_sample = 9'h000;
    adc_valid = 1'b1;
    tmstp_pin = 1'b0;
    sysref_pin = 1'b0;
    clk(2);
    rst_n <= 1'b1;
    clk(4);
    t_reset;
    t_disable;
    t_stream(1'b0);
    t_stream(1'b1);
    t_mf;
    wrap_up;
  end

  initial begin
    clk(30000);
    miscompares++;
    wrap_up;
  end
endmodule
